// file: core/cpsc_top.sv
// configuration start, port selection and lock, and test access port
`timescale 1ns/10ps
`default_nettype none
module cpsc_top #(
  parameter logic [cpsc_pkg::DR_W-1:0] IDCODE_VALUE = 32'h0000_0001  // arbitrary value
) (
  // clocks and reset
  input  wire logic                        ref_clk,
  input  wire logic                        arst_n,
  input  wire logic                        tck,
  // test access port pins
  input  wire logic                        tms,
  input  wire logic                        tdi,
  output logic                             tdo_o,
  output logic                             tdo_oe,
  // configuration pins
  input  wire logic                        config_restart_n,
  input  wire logic [cpsc_pkg::MODE_W-1:0] cfg_mode_pins,
  input  wire logic                        init_ready_n_i,
  output logic                             init_ready_n_o,
  output logic                             init_ready_n_oe,
  // towards the configuration engine
  input  wire logic                        config_done,
  output logic                             config_start,
  output logic      [cpsc_pkg::MODE_W-1:0] config_mode,
  output cpsc_pkg::cpsc_port_t             active_port,
  output logic                             switch_refused,
  output logic                             config_busy
);
  import cpsc_pkg::*;

  // ---------------- test clock domain ----------------

  // controller state and shift paths
  typedef struct packed {
    cpsc_tap_t        tap;       // controller state
    logic [IR_W-1:0]  ir_shift;  // instruction shift path
    logic [IR_W-1:0]  ir;        // current instruction
    logic [DR_W-1:0]  dr_shift;  // data shift path
    logic             cfg_tog;   // flips on each port request
  } cpsc_tck_state_t;

  // falling-edge output stage
  typedef struct packed {
    logic tdo;     // serial data out
    logic tdo_en;  // driven while shifting
  } cpsc_tdo_state_t;

  cpsc_tck_state_t t_reg;
  cpsc_tck_state_t t_next;
  cpsc_tdo_state_t o_reg;
  cpsc_tdo_state_t o_next;

  // standard controller transition on tms
  function automatic cpsc_tap_t tap_step(input cpsc_tap_t s, input logic m);
    cpsc_tap_t nx;
    nx = s;
    unique case (s)
      ts_tlr:    nx = m ? ts_tlr    : ts_rti;
      ts_rti:    nx = m ? ts_sel_dr : ts_rti;
      ts_sel_dr: nx = m ? ts_sel_ir : ts_cap_dr;
      ts_cap_dr: nx = m ? ts_ex1_dr : ts_sh_dr;
      ts_sh_dr:  nx = m ? ts_ex1_dr : ts_sh_dr;
      ts_ex1_dr: nx = m ? ts_upd_dr : ts_pa_dr;
      ts_pa_dr:  nx = m ? ts_ex2_dr : ts_pa_dr;
      ts_ex2_dr: nx = m ? ts_upd_dr : ts_sh_dr;
      ts_upd_dr: nx = m ? ts_sel_dr : ts_rti;
      ts_sel_ir: nx = m ? ts_tlr    : ts_cap_ir;
      ts_cap_ir: nx = m ? ts_ex1_ir : ts_sh_ir;
      ts_sh_ir:  nx = m ? ts_ex1_ir : ts_sh_ir;
      ts_ex1_ir: nx = m ? ts_upd_ir : ts_pa_ir;
      ts_pa_ir:  nx = m ? ts_ex2_ir : ts_pa_ir;
      ts_ex2_ir: nx = m ? ts_upd_ir : ts_sh_ir;
      ts_upd_ir: nx = m ? ts_sel_dr : ts_rti;
    endcase
    return nx;
  endfunction : tap_step

  // controller actions on the rising test clock
  always_comb begin
    t_next     = t_reg;
    t_next.tap = tap_step(t_reg.tap, tms);
    unique case (t_reg.tap)
      // reset state forces the identification instruction
      ts_tlr: begin
        t_next.ir = IR_IDCODE;
      end
      ts_cap_ir: begin
        t_next.ir_shift = IR_CAPTURE;
      end
      // lsb first, tdi enters at the top
      ts_sh_ir: begin
        t_next.ir_shift = {tdi, t_reg.ir_shift[IR_W-1:1]};
      end
      // a port request is an event; the toggle carries it across
      ts_upd_ir: begin
        t_next.ir = t_reg.ir_shift;
        if (t_reg.ir_shift == IR_CFG_ENABLE) begin
          t_next.cfg_tog = ~t_reg.cfg_tog;
        end
      end
      // every other instruction selects the one-bit bypass path
      ts_cap_dr: begin
        t_next.dr_shift = (t_reg.ir == IR_IDCODE) ? IDCODE_VALUE : DR_RESET;
      end
      ts_sh_dr: begin
        if (t_reg.ir == IR_IDCODE) begin
          t_next.dr_shift = {tdi, t_reg.dr_shift[DR_W-1:1]};
        end else begin
          t_next.dr_shift = {t_reg.dr_shift[DR_W-1:1], tdi};
        end
      end
      default: begin
      end
    endcase
  end

  // tdo changes on the falling edge so the tester samples it mid-period
  always_comb begin
    o_next        = o_reg;
    o_next.tdo_en = (t_reg.tap == ts_sh_ir) || (t_reg.tap == ts_sh_dr);
    if (t_reg.tap == ts_sh_ir) begin
      o_next.tdo = t_reg.ir_shift[0];
    end else begin
      o_next.tdo = t_reg.dr_shift[0];
    end
  end

  // rising test clock registers
  always_ff @(posedge tck or negedge arst_n) begin
    if (!arst_n) begin
      t_reg <= '{tap: ts_tlr, ir: IR_IDCODE, default: '0};
    end else begin
      t_reg <= t_next;
    end
  end

  // falling test clock registers
  always_ff @(negedge tck or negedge arst_n) begin
    if (!arst_n) begin
      o_reg <= '0;
    end else begin
      o_reg <= o_next;
    end
  end

  assign tdo_o  = o_reg.tdo;
  assign tdo_oe = o_reg.tdo_en;

  // ---------------- crossings into the reference domain ----------------

  logic              restart_n_sync;  // settled restart line
  logic              init_sync;       // settled ready line as seen on the wire
  logic              tog_sync;        // settled port request toggle
  logic [MODE_W-1:0] mode_sync;       // settled mode pins

  // pins and the toggle all pass two flip-flops
  cpsc_sync #(.WIDTH(MODE_W + 3)) u_sync (
    .clk    (ref_clk),
    .arst_n (arst_n),
    .d      ({config_restart_n, init_ready_n_i, t_reg.cfg_tog, cfg_mode_pins}),
    .q      ({restart_n_sync, init_sync, tog_sync, mode_sync})
  );

  // ---------------- reference clock domain ----------------

  // sequence, owner and edge history
  typedef struct packed {
    cpsc_cfg_state_t   st;           // start sequence state
    cpsc_port_t        port;         // locked owner, cleared only by reset
    logic [CNT_W-1:0]  cnt;          // ready-line low time
    logic [MODE_W-1:0] mode;         // captured mode
    logic              init_prev;    // ready line one cycle ago
    logic              tog_prev;     // toggle one cycle ago
    logic              restart_old;  // restart was low one cycle ago
    logic              start;        // one-cycle start pulse
    logic              refused;      // one-cycle refusal pulse
  } cpsc_ref_state_t;

  cpsc_ref_state_t r_reg;
  cpsc_ref_state_t r_next;

  logic restart_req;   // restart line is low
  logic restart_fall;  // restart line just went low
  logic restart_go;    // restart that this port owner accepts
  logic init_rise;     // ready line just went high
  logic jtag_req;      // test port asked for configuration

  // event decode from settled inputs
  always_comb begin
    restart_req  = ~restart_n_sync;
    restart_fall = restart_req & ~r_reg.restart_old;
    restart_go   = restart_req & (r_reg.port != cpsc_port_jtag);
    init_rise    = init_sync & ~r_reg.init_prev;
    jtag_req     = tog_sync ^ r_reg.tog_prev;
  end

  // start sequence and port lock
  always_comb begin
    r_next             = r_reg;
    r_next.start       = 1'h0;
    r_next.refused     = 1'h0;
    r_next.init_prev   = init_sync;
    r_next.tog_prev    = tog_sync;
    r_next.restart_old = restart_req;
    unique case (r_reg.st)
      // waiting for a restart
      cs_idle: begin
        if (restart_go) begin
          r_next.st  = cs_clear;
          r_next.cnt = CNT_RESET;
        end
      end
      // ready line held low; the count restarts while restart is low
      cs_clear: begin
        if (restart_go) begin
          r_next.cnt = CNT_RESET;
        end else if (r_reg.cnt == INIT_LOW_LAST) begin
          r_next.st = cs_wait_init;
        end else begin
          r_next.cnt = r_reg.cnt + 4'h1;
        end
      end
      // line released; the host may still hold it low to delay us
      cs_wait_init: begin
        if (restart_go) begin
          r_next.st  = cs_clear;
          r_next.cnt = CNT_RESET;
        end else if (init_rise) begin
          r_next.mode  = mode_sync;
          r_next.port  = cpsc_port_syscfg;
          r_next.start = 1'h1;
          r_next.st    = cs_config;
        end
      end
      // engine running until it reports done
      cs_config: begin
        if (restart_go) begin
          r_next.st  = cs_clear;
          r_next.cnt = CNT_RESET;
        end else if (config_done) begin
          r_next.st = cs_idle;
        end
      end
    endcase
    // restart is a pin event; report it once per falling edge
    if (restart_fall && (r_reg.port == cpsc_port_jtag)) begin
      r_next.refused = 1'h1;
    end
    // test port wins only while nothing is locked
    if (jtag_req) begin
      if (r_next.port == cpsc_port_none) begin
        r_next.port  = cpsc_port_jtag;
        r_next.st    = cs_config;
        r_next.cnt   = CNT_RESET;
        r_next.start = 1'h1;
      end else if (r_next.port == cpsc_port_syscfg) begin
        r_next.refused = 1'h1;
      end
    end
  end

  // power-up enters the low phase so the ready line is driven at once
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= '{st: cs_clear, port: cpsc_port_none, cnt: CNT_RESET, mode: MODE_RESET,
                 default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // open drain: only ever pulls low
  assign init_ready_n_o  = 1'h0;
  assign init_ready_n_oe = (r_reg.st == cs_clear);
  assign config_start    = r_reg.start;
  assign config_mode     = r_reg.mode;
  assign active_port     = r_reg.port;
  assign switch_refused  = r_reg.refused;
  assign config_busy     = (r_reg.st != cs_idle);

  // ---------------- checks ----------------

  sequence s_sys_capture;
    (r_reg.st == cs_wait_init) && init_rise && !restart_go && !jtag_req;
  endsequence

  sequence s_tms_high5;
    tms [*5];
  endsequence

  AST_RESTART_CLEAR: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (restart_go && !jtag_req) |=> (r_reg.st == cs_clear) && init_ready_n_oe)
    else $error("restart did not hold ready line low");

  // the low phase may not end before its count runs out, unless the test port takes over
  AST_INIT_OPEN_DRAIN: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ((r_reg.st == cs_clear) && (r_reg.cnt != INIT_LOW_LAST) && !jtag_req)
    |=> (init_ready_n_o == 1'h0) && init_ready_n_oe)
    else $error("ready line not pulled low during low phase");

  AST_MODE_CAPTURE: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_sys_capture |=> (config_mode == $past(mode_sync)) && config_start ##1 !config_start)
    else $error("mode not captured on ready rising edge");

  AST_JTAG_TAKE: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (jtag_req && (r_reg.port == cpsc_port_none)
     && !((r_reg.st == cs_wait_init) && init_rise && !restart_go))
    |=> (active_port == cpsc_port_jtag) && config_start)
    else $error("test port request not granted");

  AST_PORT_LOCK: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (active_port != cpsc_port_none) |=> $stable(active_port))
    else $error("locked port changed");

  AST_SWITCH_REFUSED: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (jtag_req && (r_reg.port == cpsc_port_syscfg)) |=> switch_refused && $stable(active_port))
    else $error("port switch not refused");

  AST_TAP_RESET: assert property (@(posedge tck) disable iff (!arst_n)
    s_tms_high5 |=> (t_reg.tap == ts_tlr))
    else $error("five tms highs did not reach reset state");

  AST_TDO_SHIFT: assert property (@(posedge tck) disable iff (!arst_n)
    (t_reg.tap == ts_sh_ir) |-> tdo_oe && (tdo_o == t_reg.ir_shift[0]))
    else $error("tdo does not follow instruction shift path");

  AST_TDI_LOAD: assert property (@(posedge tck) disable iff (!arst_n)
    ((t_reg.tap == ts_sh_dr) && (t_reg.ir == IR_IDCODE))
    |=> (t_reg.dr_shift[DR_W-1] == $past(tdi)))
    else $error("tdi not loaded into data path");

  AST_CFG_TOGGLE: assert property (@(posedge tck) disable iff (!arst_n)
    ((t_reg.tap == ts_upd_ir) && (t_reg.ir_shift == IR_CFG_ENABLE))
    |=> (t_reg.cfg_tog != $past(t_reg.cfg_tog)))
    else $error("port request event not raised");

endmodule : cpsc_top
`default_nettype wire

// file: core/cpsc_pkg.sv
// constants and types shared by the configuration port select control block
package cpsc_pkg;

  // reference clock and ready-line low time
  localparam int REF_CLK_PERIOD_NS = 100;   // 10 MHz
  localparam int INIT_LOW_NS       = 1000;  // least time ready line held low
  localparam int INIT_LOW_CYCLES   = (INIT_LOW_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
  localparam int CNT_W             = 4;     // wide enough for the low-time count
  localparam logic [CNT_W-1:0] INIT_LOW_LAST = CNT_W'(INIT_LOW_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_RESET     = 4'h0;

  // mode pins
  localparam int MODE_W = 3;
  localparam logic [MODE_W-1:0] MODE_RESET = 3'h0;

  // test access port instruction register
  localparam int IR_W = 8;
  localparam logic [IR_W-1:0] IR_CAPTURE    = 8'h01;  // fixed capture pattern
  localparam logic [IR_W-1:0] IR_BYPASS     = 8'hFF;
  localparam logic [IR_W-1:0] IR_IDCODE     = 8'h16;  // arbitrary code
  localparam logic [IR_W-1:0] IR_CFG_ENABLE = 8'hC6;  // arbitrary code
  localparam int DR_W = 32;
  localparam logic [DR_W-1:0] DR_RESET = 32'h0000_0000;

  // configuration port owner
  typedef enum logic [1:0] {
    cpsc_port_none,
    cpsc_port_syscfg,
    cpsc_port_jtag
  } cpsc_port_t;

  // configuration start sequence
  typedef enum logic [1:0] {
    cs_idle,
    cs_clear,
    cs_wait_init,
    cs_config
  } cpsc_cfg_state_t;

  // boundary-scan controller states
  typedef enum logic [3:0] {
    ts_tlr, ts_rti,
    ts_sel_dr, ts_cap_dr, ts_sh_dr, ts_ex1_dr, ts_pa_dr, ts_ex2_dr, ts_upd_dr,
    ts_sel_ir, ts_cap_ir, ts_sh_ir, ts_ex1_ir, ts_pa_ir, ts_ex2_ir, ts_upd_ir
  } cpsc_tap_t;

endpackage : cpsc_pkg

// file: core/cpsc_sync.sv
// two flip-flop synchroniser for levels entering the reference domain
`timescale 1ns/10ps
`default_nettype none
module cpsc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             arst_n,
  // level in and synchronised level out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  // both stages in one state word
  typedef struct packed {
    logic [WIDTH-1:0] s1;  // first stage, read only by the second
    logic [WIDTH-1:0] s2;  // settled copy
  } cpsc_sync_state_t;

  cpsc_sync_state_t r_reg;
  cpsc_sync_state_t r_next;

  // shift one stage per edge
  always_comb begin
    r_next    = r_reg;
    r_next.s1 = d;
    r_next.s2 = r_reg.s1;
  end

  // constant reset only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q = r_reg.s2;

endmodule : cpsc_sync
`default_nettype wire

// file: verification/cpsc_host_model.sv
// configuration host and boundary-scan tester model at the block's pins
`timescale 1ns/10ps
`default_nettype none
module cpsc_host_model (
  // pins driven by the block
  input  wire logic init_ready_n_o,
  input  wire logic init_ready_n_oe,
  input  wire logic tdo_o,
  // pins driven towards the block
  output logic      init_ready_n_i,
  output logic      tck,
  output logic      tms,
  output logic      tdi
);
  logic hold_low;  // host stretches the ready line low to delay capture

  // open-drain wire with pull-up: low while any party pulls
  assign init_ready_n_i = !((init_ready_n_oe && !init_ready_n_o) || hold_low);

  // tck idles low between frames, pulled-up pins idle high
  initial begin
    tck      = 1'b0;
    tms      = 1'b1;
    tdi      = 1'b1;
    hold_low = 1'b1;
  end

  // one test clock period; tdo is taken just before the rising edge
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #40;
    o   = tdo_o;
    tck = 1'b1;
    #40;
    tck = 1'b0;
  endtask : step

  // five highs reach reset from anywhere, then park in idle
  task automatic tap_reset();
    logic o;
    repeat (5) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask : tap_reset

  // one instruction or data scan from idle back to idle, lsb first
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b1, o);
    if (ir) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);  // capture
    step(1'b0, 1'b1, o);  // into shift
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b1, o);  // update
    step(1'b0, 1'b1, o);
  endtask : scan
endmodule : cpsc_host_model
`default_nettype wire

// file: verification/config_port_select_control_tb.sv
// self-checking bench for configuration start, port lock and test port
`timescale 1ns/10ps
`default_nettype none
module config_port_select_control_tb;
  import cpsc_pkg::*;
  localparam logic [31:0] ID_VAL = 32'h5A3C_96E1;  // arbitrary value

  logic ref_clk, arst_n, tck, tms, tdi, tdo_o, tdo_oe;
  logic config_restart_n, init_ready_n_i, init_ready_n_o, init_ready_n_oe;
  logic config_done, config_start, switch_refused, config_busy;
  logic [2:0] cfg_mode_pins, config_mode, m;
  logic [31:0] d, q;
  cpsc_port_t active_port;
  int num_errors = 0;
  int checks     = 0;

  cpsc_top #(.IDCODE_VALUE(ID_VAL)) uut (
    .ref_clk(ref_clk), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_o(tdo_o), .tdo_oe(tdo_oe), .config_restart_n(config_restart_n),
    .cfg_mode_pins(cfg_mode_pins), .init_ready_n_i(init_ready_n_i),
    .init_ready_n_o(init_ready_n_o), .init_ready_n_oe(init_ready_n_oe),
    .config_done(config_done), .config_start(config_start),
    .config_mode(config_mode), .active_port(active_port),
    .switch_refused(switch_refused), .config_busy(config_busy));

  cpsc_host_model host (
    .init_ready_n_o(init_ready_n_o), .init_ready_n_oe(init_ready_n_oe),
    .tdo_o(tdo_o), .init_ready_n_i(init_ready_n_i), .tck(tck), .tms(tms), .tdi(tdi));

  // reference clock, 100 ns period
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  function automatic logic pick(input int w);
    case (w)
      0: pick = config_start;
      1: pick = switch_refused;
      2: pick = init_ready_n_oe;
      default: pick = !init_ready_n_oe;
    endcase
  endfunction : pick

  // bypass shifts out its captured zero first, then the bits fed in
  function automatic logic [7:0] byp_exp(input logic [31:0] v);
    return {v[6:0], 1'b0};
  endfunction : byp_exp

  // bounded wait; a pulse must also be gone one cycle later
  task automatic wait_hi(input int w, input int lim, input logic one);
    int k;
    k = 0;
    while (pick(w) !== 1'b1 && k < lim) begin
      @(negedge ref_clk);
      k++;
    end
    if (pick(w) !== 1'b1) begin
      chk(32'h0, 32'h1);
      give_verdict();
    end
    if (one) begin
      @(negedge ref_clk);
      chk(pick(w), 1'b0);
    end
  endtask : wait_hi

  // reset with the test clock walking so both domains see it
  task automatic do_reset();
    arst_n = 1'b0;
    fork
      repeat (6) @(negedge ref_clk);
      host.tap_reset();
    join
    chk(init_ready_n_oe, 1'b1);
    chk(active_port, cpsc_port_none);
    chk(init_ready_n_o, 1'b0);
    arst_n = 1'b1;
    repeat (INIT_LOW_CYCLES - 1) @(negedge ref_clk);
    chk(init_ready_n_oe, 1'b1);
    wait_hi(3, 8, 1'b0);
  endtask : do_reset

  task automatic done_test(input string s);
    $display("test %s done: checks=%0d errors=%0d", s, checks, num_errors);
  endtask : done_test

  initial begin
    void'($urandom(32'h2634));
    config_restart_n = 1'b1;
    cfg_mode_pins    = 3'h0;
    config_done      = 1'b0;
    do_reset();
    done_test("reset");
    // mode capture on ready release, corner and random modes
    for (int i = 0; i < 4; i++) begin
      m = (i == 0) ? 3'h7 : (i == 1) ? 3'h0 : 3'($urandom);
      cfg_mode_pins = m;
      repeat (4) @(negedge ref_clk);
      host.hold_low = 1'b0;
      wait_hi(0, 10, 1'b1);
      chk(config_mode, m);
      chk(active_port, cpsc_port_syscfg);
      cfg_mode_pins = ~m;
      if (i != 2) begin
        config_done = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk(config_busy, 1'b0);
        config_done = 1'b0;
      end
      host.hold_low = 1'b1;
      config_restart_n = 1'b0;
      wait_hi(2, 5, 1'b0);
      chk(config_busy, 1'b1);
      repeat (2) @(negedge ref_clk);
      config_restart_n = 1'b1;
      wait_hi(3, 20, 1'b0);
    end
    done_test("capture");
    // test port request while the other port holds the lock
    host.tap_reset();
    fork
      host.scan(1'b1, 8, IR_CFG_ENABLE, q);
      wait_hi(1, 60, 1'b1);
    join
    chk(q[7:0], IR_CAPTURE);
    chk(active_port, cpsc_port_syscfg);
    done_test("refuse");
    // identity and bypass data paths
    host.tap_reset();
    host.scan(1'b0, 32, $urandom, q);
    chk(q, ID_VAL);
    host.scan(1'b1, 8, IR_BYPASS, q);
    d = $urandom;
    host.scan(1'b0, 8, d, q);
    chk(q[7:0], byp_exp(d));
    host.scan(1'b1, 8, IR_IDCODE, q);
    host.scan(1'b0, 32, d, q);
    chk(q, ID_VAL);
    @(negedge ref_clk);
    chk(tdo_oe, 1'b0);
    done_test("tap");
    // after power-up again the test port may take the lock
    do_reset();
    host.tap_reset();
    fork
      host.scan(1'b1, 8, IR_CFG_ENABLE, q);
      wait_hi(0, 60, 1'b1);
    join
    chk(active_port, cpsc_port_jtag);
    host.hold_low = 1'b0;
    repeat (5) @(negedge ref_clk);
    chk(config_start, 1'b0);
    config_restart_n = 1'b0;
    wait_hi(1, 6, 1'b1);
    chk(init_ready_n_oe, 1'b0);
    chk(active_port, cpsc_port_jtag);
    config_restart_n = 1'b1;
    done_test("jtag");
    give_verdict();
  end
endmodule : config_port_select_control_tb
`default_nettype wire
